// file: logic/fbs_cfg.svh
// fbs_cfg.svh: offsets, field positions and reset values
// for the frame buffer port and buffer flip block; definitions only.
`ifndef FBS_CFG_SVH
`define FBS_CFG_SVH

// address windows, relative to memory_window_base
`define FBS_LFB_OFFSET 32'h0080_0000
`define FBS_LFB_SPAN 32'h0040_0000
`define FBS_REG_SPAN 32'h0000_1000

// register byte offsets inside the register window
`define FBS_REG_STATUS 12'h000
`define FBS_REG_PIXCFG 12'h004
`define FBS_REG_PORTMODE 12'h008
`define FBS_REG_CDA 12'h00C
`define FBS_REG_FLIPCMD 12'h010
`define FBS_REG_DIMS 12'h014
`define FBS_REG_BUFMODE 12'h018

// field positions
`define FBS_PEND_HI 30
`define FBS_PEND_LO 28
`define FBS_FLIP_SYNC 0
`define FBS_INTV_HI 8
`define FBS_INTV_LO 1
`define FBS_PIX_CLIP 0
`define FBS_PIX_YORG 16
`define FBS_PM_FMT_HI 3
`define FBS_PM_FMT_LO 0
`define FBS_PM_RBSWAP 9
`define FBS_PM_ALO 10
`define FBS_PM_HALF 11
`define FBS_DIM_W_HI 9
`define FBS_DIM_W_LO 0
`define FBS_DIM_H_HI 25
`define FBS_DIM_H_LO 16

// reset value and pending count ceiling
`define FBS_RST_WORD 32'h0000_0000
`define FBS_PEND_MAX 3'h7

`endif

// file: logic/fbs_pkg.sv
// fbs_pkg: types of the frame buffer port and buffer flip block.
// defines its own codes and widths; takes nothing from fbs_cfg.svh.
package fbs_pkg;
   typedef enum logic [3:0] {
      FMT_565 = 4'h0,
      FMT_X555 = 4'h1,
      FMT_1555 = 4'h2,
      FMT_A555 = 4'h3,
      FMT_888 = 4'h4,
      FMT_8888 = 4'h5,
      FMT_Z565 = 4'hC,
      FMT_Z555 = 4'hD,
      FMT_Z1555 = 4'hE,
      FMT_ZZ = 4'hF
   } fbs_fmt_t;

   typedef enum logic [2:0] {
      B_IDLE = 3'h0,
      B_RDWAIT = 3'h1,
      B_RD0 = 3'h3,
      B_RD1 = 3'h2,
      B_RDDONE = 3'h6,
      B_WR2 = 3'h4
   } fbs_bus_t;

   typedef enum logic [1:0] {
      S_IDLE = 2'h0,
      S_WAITVR = 2'h1,
      S_STALL = 2'h2
   } fbs_swp_t;

   typedef struct packed {
      logic [9:0] x;
      logic [9:0] y;
      logic [23:0] color;
      logic [7:0] alpha;
      logic [15:0] depth;
      logic cwe;
      logic dwe;
   } fbs_px_t;

   typedef struct packed {
      fbs_bus_t bus;
      fbs_swp_t swp;
      logic vr_s1;
      logic vr_s2;
      logic vr_d;
      logic [2:0] pend;
      logic [1:0] front;
      logic tri_flag;
      logic [8:0] vr_cnt;
      logic [7:0] intv;
      logic [31:0] pixcfg;
      logic [31:0] pmode;
      logic [31:0] cda;
      logic [31:0] dims;
      logic tribuf;
      logic [31:0] rdata;
      logic [31:0] lat_w;
      logic [9:0] lat_x;
      logic [9:0] lat_y;
      logic pix_wr;
      logic pix_rd;
      fbs_px_t px;
   } fbs_st_t;
endpackage

// file: logic/fbs_top.sv
// fbs_top: host linear frame buffer port and buffer flip control.
// assumes an avalon-mm master with byte addresses, a pixel memory port
// that answers a read strobe with PIX_RVALID at least one cycle later,
// and same-clock HOST_FIFO_EMPTY / PIPE_IDLE from the command front end.
//
// Behaviour
// RL1 - flip command bit 0 chooses retrace-synchronised or immediate flip.
// RL2 - synced double buffering stalls the flip command until retrace is active.
// RL3 - count retraces; flip display pointer once count exceeds bits 8:1.
// RL4 - synced triple buffering sets a flag; refresh flips at next retrace.
// RL5 - pending count bits 30:28 rises on command entry, falls on flip.
// RL6 - triple buffering with swaps pending stalls a new command until retrace.
// RL7 - frame buffer window sits 8 Mbyte above base and spans 4 Mbyte.
// RL8 - addresses map with a 1024-pixel logical line.
// RL9 - pixel mode bit 16 picks top or bottom origin; x grows rightward.
// RL10 - writes are clipped only when pixel mode bit 0 is set.
// RL11 - port mode bits 3:0 give the write format; reserved codes drop.
// RL12 - 16-bit formats: 2048 bytes a line, two pixels placed by bit 11.
// RL13 - formats 0-3 take depth from constant; alpha constant except format 3.
// RL14 - channel order follows port mode bits 10:9 on writes and reads.
// RL15 - formats 4 and 5 are one word-aligned pixel a word, 4096 bytes a line.
// RL16 - formats 4-5 take constant depth; alpha constant for 4, data for 5.
// RL17 - formats 12-14 one pixel a word; bit 11 places the 16-bit halves.
// RL18 - reads return two 16-bit pixels a word, ordered by bit 11.
// RL19 - reads hold the bus until host fifo empty and pipeline flushed.
// RL20 - host should check idle and empty fifos before reading.
// RL21 - host uses only 32-bit or 16-bit accesses, never bytes.
// RL22 - i/o space cycles are ignored; only memory cycles act.
// RL23 - pending count saturates at both ends.
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`include "fbs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module fbs_top (
   input wire logic CLOCK, // 10 MHz core clock
   input wire logic RST, // async reset, active high
   input wire logic [31:0] MEM_BASE, // memory_window_base from config space
   input wire logic [31:0] AVS_ADDRESS, // byte address
   input wire logic [3:0] AVS_BYTEENABLE, // byte lanes
   input wire logic AVS_READ, // read request
   input wire logic AVS_WRITE, // write request
   input wire logic [31:0] AVS_WRITEDATA, // write data
   input wire logic AVS_IOSPACE, // high for an i/o space cycle
   output logic [31:0] AVS_READDATA, // read data
   output logic AVS_WAITREQUEST, // stall
   input wire logic VRETRACE, // vertical retrace pin, async
   input wire logic HOST_FIFO_EMPTY, // host fifo drained
   input wire logic PIPE_IDLE, // pixel pipeline flushed
   output logic [1:0] DISPLAY_BUF, // buffer shown by refresh
   output logic PIX_WR, // pixel write strobe
   output logic PIX_RD, // pixel read strobe
   output logic [9:0] PIX_X, // pixel column
   output logic [9:0] PIX_Y, // pixel row in memory
   output logic [23:0] PIX_COLOR, // rgb 8-8-8
   output logic [7:0] PIX_ALPHA, // alpha
   output logic [15:0] PIX_DEPTH, // depth
   output logic PIX_CWE, // colour write enable
   output logic PIX_DWE, // depth write enable
   input wire logic [15:0] PIX_RDATA, // 5-6-5 pixel from memory
   input wire logic PIX_RVALID // read data valid
);
   import fbs_pkg::*;

   fbs_st_t s;
   fbs_st_t n;

   function automatic logic [7:0] fbs_x5(input logic [4:0] v);
      fbs_x5 = {v, v[4:2]};
   endfunction
   // 16-bit colour to {alpha, r, g, b}; kind 0 is 5-6-5, others 1-5-5-5
   function automatic logic [31:0] fbs_c16(input logic [1:0] kind,
                                           input logic [15:0] d,
                                           input logic sw);
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
      logic [7:0] a;
      a = {8{d[15]}};
      if (kind == 2'h0) begin
         r = fbs_x5(d[15:11]);
         g = {d[10:5], d[10:9]};
         b = fbs_x5(d[4:0]);
      end else begin
         r = fbs_x5(d[14:10]);
         g = fbs_x5(d[9:5]);
         b = fbs_x5(d[4:0]);
      end
      fbs_c16 = sw ? {a, b, g, r} : {a, r, g, b};
   endfunction

   // 32-bit colour; ord[1] takes alpha from the low byte
   function automatic logic [31:0] fbs_c32(input logic [31:0] w,
                                           input logic [1:0] ord);
      logic [31:0] c;
      c = ord[1] ? {w[7:0], w[31:8]} : w;
      fbs_c32 = ord[0] ? {c[31:24], c[7:0], c[15:8], c[23:16]} : c;
   endfunction
   function automatic logic [9:0] fbs_yflip(input logic [9:0] y,
                                            input logic [9:0] h,
                                            input logic bottom);
      fbs_yflip = bottom ? (h - y - 10'h001) : y; // [RL9]
   endfunction
   // one pixel of a write word; slot picks the half for 16-bit formats
   function automatic fbs_px_t fbs_pixel(input logic [3:0] fmt,
                                         input logic [31:0] w,
                                         input logic slot,
                                         input logic [31:0] pm,
                                         input logic [31:0] cda);
      fbs_px_t p;
      logic [15:0] h;
      logic [15:0] col;
      logic [15:0] oth;
      logic [31:0] c;
      p = '0;
      h = slot ? w[31:16] : w[15:0];
      col = pm[`FBS_PM_HALF] ? w[31:16] : w[15:0]; // [RL17]
      oth = pm[`FBS_PM_HALF] ? w[15:0] : w[31:16];
      c = '0;
      p.alpha = cda[31:24];
      p.depth = cda[15:0];
      p.cwe = 1'b1;
      p.dwe = 1'b1;
      case (fbs_fmt_t'(fmt)) // [RL11]
         FMT_565, FMT_X555, FMT_1555, FMT_A555: begin
            c = fbs_c16(fmt[1:0], h, pm[`FBS_PM_RBSWAP]); // [RL14]
            if (fmt == FMT_A555) begin
               p.alpha = c[31:24]; // [RL13]
            end
         end
         FMT_888, FMT_8888: begin
            c = fbs_c32(w, pm[`FBS_PM_ALO:`FBS_PM_RBSWAP]); // [RL14]
            if (fmt == FMT_8888) begin
               p.alpha = c[31:24]; // [RL16]
            end
         end
         FMT_Z565, FMT_Z555, FMT_Z1555: begin
            c = fbs_c16(fmt[1:0], col, pm[`FBS_PM_RBSWAP]);
            p.depth = oth; // [RL17]
            if (fmt == FMT_Z1555) begin
               p.alpha = c[31:24];
            end
         end
         FMT_ZZ: begin
            p.cwe = 1'b0;
            p.depth = h;
         end
         default: begin
            p.cwe = 1'b0;
            p.dwe = 1'b0;
         end
      endcase
      p.color = c[23:0];
      fbs_pixel = p;
   endfunction

   function automatic logic [15:0] fbs_rd16(input logic [15:0] d,
                                            input logic sw);
      fbs_rd16 = sw ? {d[4:0], d[10:5], d[15:11]} : d; // [RL14]
   endfunction
   logic [31:0] off;
   logic [11:0] roff;
   logic in_reg;
   logic in_lfb;
   logic [3:0] fmt;
   logic wide;
   logic fmt_ok;
   logic be_ok;
   logic flip_wr;
   logic vr_rise;
   logic [9:0] wx;
   logic [9:0] wy;
   logic [9:0] rx;
   logic [9:0] ry;
   logic [9:0] scr_w;
   logic [9:0] scr_h;
   logic [31:0] rv;

   assign off = AVS_ADDRESS - MEM_BASE;
   // io cycles never decode, so they fall through as unmapped [RL22]
   assign in_reg = ~AVS_IOSPACE & (off < `FBS_REG_SPAN);
   assign in_lfb = ~AVS_IOSPACE & (off >= `FBS_LFB_OFFSET) // [RL7]
                   & (off < (`FBS_LFB_OFFSET + `FBS_LFB_SPAN));
   assign roff = off[11:0];
   assign fmt = s.pmode[`FBS_PM_FMT_HI:`FBS_PM_FMT_LO];
   assign wide = (fmt == FMT_888) | (fmt == FMT_8888) | (fmt == FMT_Z565)
                 | (fmt == FMT_Z555) | (fmt == FMT_Z1555);
   assign fmt_ok = (fmt <= FMT_8888) | (fmt >= FMT_Z565); // [RL11]
   // word-wide formats need the whole word; halfwords only for 16-bit
   assign be_ok = (AVS_BYTEENABLE == 4'hF) | (~wide & ((AVS_BYTEENABLE == 4'h3)
                  | (AVS_BYTEENABLE == 4'hC))); // [RL15]
   assign flip_wr = AVS_WRITE & in_reg & (roff == `FBS_REG_FLIPCMD);
   assign vr_rise = s.vr_s2 & ~s.vr_d;
   assign scr_w = s.dims[`FBS_DIM_W_HI:`FBS_DIM_W_LO];
   assign scr_h = s.dims[`FBS_DIM_H_HI:`FBS_DIM_H_LO];
   // 1024-pixel logical line: 4096 bytes wide, 2048 bytes 16-bit [RL8]
   assign wx = wide ? off[11:2] : {off[10:2], 1'b0}; // [RL15] [RL12]
   assign wy = wide ? off[21:12] : off[20:11];
   assign rx = {off[10:2], 1'b0}; // [RL18]
   assign ry = off[20:11];

   always_comb begin
      rv = `FBS_RST_WORD;
      if (in_reg) begin
         case (roff)
            `FBS_REG_STATUS: begin
               rv[`FBS_PEND_HI:`FBS_PEND_LO] = s.pend; // [RL5]
               rv[5:4] = s.front;
               rv[3] = PIPE_IDLE;
               rv[2] = HOST_FIFO_EMPTY;
               rv[1] = (s.swp != S_IDLE) | s.tri_flag;
               rv[0] = s.vr_s2;
            end
            `FBS_REG_PIXCFG: rv = s.pixcfg;
            `FBS_REG_PORTMODE: rv = s.pmode;
            `FBS_REG_CDA: rv = s.cda;
            `FBS_REG_DIMS: rv = s.dims;
            `FBS_REG_BUFMODE: rv[0] = s.tribuf;
            default: rv = `FBS_RST_WORD;
         endcase
      end
   end

   always_comb begin
      case (s.bus)
         // reads always take at least one wait cycle so data leaves a flip-flop
         B_IDLE: AVS_WAITREQUEST = AVS_READ | (flip_wr & (s.swp != S_IDLE)); // [RL2]
         B_RDDONE: AVS_WAITREQUEST = 1'b0;
         default: AVS_WAITREQUEST = 1'b1;
      endcase
   end

   always_comb begin
      fbs_px_t p;
      logic take;
      logic flip;
      p = '0;
      take = 1'b0;
      flip = 1'b0;
      n = s;
      n.vr_s1 = VRETRACE;
      n.vr_s2 = s.vr_s1;
      n.vr_d = s.vr_s2;
      n.pix_wr = 1'b0;
      n.pix_rd = 1'b0;

      case (s.bus)
         B_IDLE: begin
            if (AVS_WRITE & ~AVS_WAITREQUEST) begin
               if (in_reg) begin
                  case (roff)
                     `FBS_REG_PIXCFG: n.pixcfg = AVS_WRITEDATA;
                     `FBS_REG_PORTMODE: n.pmode = AVS_WRITEDATA;
                     `FBS_REG_CDA: n.cda = AVS_WRITEDATA;
                     `FBS_REG_DIMS: n.dims = AVS_WRITEDATA;
                     `FBS_REG_BUFMODE: n.tribuf = AVS_WRITEDATA[0];
                     `FBS_REG_FLIPCMD: take = 1'b1;
                     default: n.tribuf = s.tribuf;
                  endcase
               end else if (in_lfb & be_ok & fmt_ok) begin
                  p = fbs_pixel(fmt, AVS_WRITEDATA, ~AVS_BYTEENABLE[0],
                                s.pmode, s.cda);
                  p.x = wide ? wx : {wx[9:1], ~AVS_BYTEENABLE[0] ^ s.pmode[`FBS_PM_HALF]};
                  // scissor only when enabled; else off-screen is host's risk
                  if (~(s.pixcfg[`FBS_PIX_CLIP] & ((p.x >= scr_w) | (wy >= scr_h)))) begin
                     n.pix_wr = 1'b1; // [RL10]
                  end
                  p.y = fbs_yflip(wy, scr_h, s.pixcfg[`FBS_PIX_YORG]);
                  n.px = p;
                  n.lat_w = AVS_WRITEDATA;
                  n.lat_x = wx;
                  n.lat_y = wy;
                  if (~wide & (AVS_BYTEENABLE == 4'hF)) begin
                     n.bus = B_WR2; // [RL12]
                  end
               end
            end else if (AVS_READ) begin
               if (in_lfb) begin
                  n.lat_x = rx;
                  n.lat_y = fbs_yflip(ry, scr_h, s.pixcfg[`FBS_PIX_YORG]);
                  n.bus = B_RDWAIT;
               end else begin
                  n.rdata = rv;
                  n.bus = B_RDDONE;
               end
            end
         end
         B_WR2: begin
            p = fbs_pixel(fmt, s.lat_w, 1'b1, s.pmode, s.cda);
            p.x = {s.lat_x[9:1], ~s.pmode[`FBS_PM_HALF]}; // [RL12]
            if (~(s.pixcfg[`FBS_PIX_CLIP] & ((p.x >= scr_w) | (s.lat_y >= scr_h)))) begin
               n.pix_wr = 1'b1; // [RL10]
            end
            p.y = fbs_yflip(s.lat_y, scr_h, s.pixcfg[`FBS_PIX_YORG]);
            n.px = p;
            n.bus = B_IDLE;
         end
         B_RDWAIT: begin
            // memory is not sampled before earlier commands have drained
            if (HOST_FIFO_EMPTY & PIPE_IDLE) begin // [RL19]
               n.pix_rd = 1'b1;
               n.px.x = {s.lat_x[9:1], s.pmode[`FBS_PM_HALF]}; // [RL18]
               n.px.y = s.lat_y;
               n.bus = B_RD0;
            end
         end
         B_RD0: begin
            if (PIX_RVALID) begin
               n.rdata[15:0] = fbs_rd16(PIX_RDATA, s.pmode[`FBS_PM_RBSWAP]);
               n.pix_rd = 1'b1;
               n.px.x = {s.lat_x[9:1], ~s.pmode[`FBS_PM_HALF]}; // [RL18]
               n.bus = B_RD1;
            end
         end
         B_RD1: begin
            if (PIX_RVALID) begin
               n.rdata[31:16] = fbs_rd16(PIX_RDATA, s.pmode[`FBS_PM_RBSWAP]);
               n.bus = B_RDDONE;
            end
         end
         default: n.bus = B_IDLE;
      endcase

      // refresh side: armed triple-buffer flip lands on the next retrace
      if (s.tri_flag & vr_rise) begin
         flip = 1'b1; // [RL4]
         n.tri_flag = 1'b0;
      end

      case (s.swp)
         S_IDLE: begin
            if (take) begin
               if (~AVS_WRITEDATA[`FBS_FLIP_SYNC]) begin
                  flip = 1'b1; // [RL1]
               end else if (~s.tribuf) begin
                  n.vr_cnt = '0;
                  n.intv = AVS_WRITEDATA[`FBS_INTV_HI:`FBS_INTV_LO]; // [RL3]
                  n.swp = S_WAITVR; // [RL2]
               end else if (s.pend != 3'h0) begin
                  n.swp = S_STALL; // [RL6]
               end else begin
                  n.tri_flag = 1'b1; // [RL4]
               end
            end
         end
         S_WAITVR: begin
            if (vr_rise) begin
               n.vr_cnt = s.vr_cnt + 9'h001;
               if ((s.vr_cnt + 9'h001) > {1'b0, s.intv}) begin
                  flip = 1'b1; // [RL3]
                  n.swp = S_IDLE;
               end
            end
         end
         S_STALL: begin
            // wait for the earlier flip to land so the front stays intact
            if (s.vr_s2 & ~n.tri_flag) begin
               n.tri_flag = 1'b1; // [RL6]
               n.swp = S_IDLE;
            end
         end
         default: n.swp = S_IDLE;
      endcase

      if (flip) begin
         if (s.tribuf) begin
            n.front = (s.front == 2'h2) ? 2'h0 : s.front + 2'h1;
         end else begin
            n.front = {1'b0, ~s.front[0]};
         end
      end
      // simultaneous entry and flip leave the count unchanged
      if (take & ~flip & (s.pend != `FBS_PEND_MAX)) begin
         n.pend = s.pend + 3'h1; // [RL5] [RL23]
      end else if (flip & ~take & (s.pend != 3'h0)) begin
         n.pend = s.pend - 3'h1; // [RL5] [RL23]
      end
   end
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end
   assign AVS_READDATA = s.rdata;
   assign DISPLAY_BUF = s.front;
   assign PIX_WR = s.pix_wr;
   assign PIX_RD = s.pix_rd;
   assign PIX_X = s.px.x;
   assign PIX_Y = s.px.y;
   assign PIX_COLOR = s.px.color;
   assign PIX_ALPHA = s.px.alpha;
   assign PIX_DEPTH = s.px.depth;
   assign PIX_CWE = s.px.cwe;
   assign PIX_DWE = s.px.dwe;
endmodule

`default_nettype wire

// file: verif/fbs_chk_sva.sv
// fbs_chk_sva: port-level checks of the frame buffer port and flip logic.
// assumes the fbs_top port list; the bind sits after the module.
`timescale 1ns/100ps
`default_nettype none
module fbs_chk (
   input wire logic CLOCK, // core clock
   input wire logic RST, // async reset
   input wire logic [31:0] MEM_BASE, // window base
   input wire logic [31:0] AVS_ADDRESS, // byte address
   input wire logic AVS_READ, // read request
   input wire logic AVS_WRITE, // write request
   input wire logic [31:0] AVS_WRITEDATA, // write data
   input wire logic AVS_IOSPACE, // io cycle
   input wire logic [31:0] AVS_READDATA, // read data
   input wire logic AVS_WAITREQUEST, // stall
   input wire logic HOST_FIFO_EMPTY, // fifo drained
   input wire logic PIPE_IDLE, // pipe flushed
   input wire logic [1:0] DISPLAY_BUF, // shown buffer
   input wire logic PIX_WR, // pixel write strobe
   input wire logic PIX_RD, // pixel read strobe
   input wire logic PIX_RVALID // read data valid
);
   logic [31:0] off;
   logic lfb;
   logic acc_wr;
   assign off = AVS_ADDRESS - MEM_BASE;
   assign lfb = !AVS_IOSPACE && off >= 32'h0080_0000 && off < 32'h00C0_0000;
   assign acc_wr = AVS_WRITE && !AVS_WAITREQUEST;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   a_rd_strobe_single: assert property (PIX_RD |=> !PIX_RD)
      else $error("pixel read strobe longer than one cycle");
   a_rd_after_drain: assert property (PIX_RD && !$past(PIX_RVALID)
      |-> $past(HOST_FIFO_EMPTY && PIPE_IDLE))
      else $error("pixel read before fifo drained and pipe flushed");
   a_lfb_rd_stall: assert property ($rose(AVS_READ) && lfb |-> AVS_WAITREQUEST)
      else $error("frame buffer read answered at once");
   a_lfb_rd_answer: assert property (AVS_READ && lfb && !AVS_WAITREQUEST
      |-> $past(PIX_RVALID))
      else $error("frame buffer read answered without pixel data");
   a_io_read_zero: assert property (AVS_READ && AVS_IOSPACE && !AVS_WAITREQUEST
      |-> AVS_READDATA == 32'h0000_0000)
      else $error("io read returned data");
   a_io_write_drop: assert property (acc_wr && AVS_IOSPACE |=> !PIX_WR ##1 !PIX_WR)
      else $error("io write reached the pixel port");
   a_flip_now: assert property (acc_wr && !AVS_IOSPACE && off == 32'h0000_0010
      && !AVS_WRITEDATA[0] |-> ##[1:3] $changed(DISPLAY_BUF))
      else $error("unsynced flip did not move the display buffer");
   a_buf_range: assert property (DISPLAY_BUF != 2'h3)
      else $error("display buffer index out of range");
endmodule
bind fbs_top fbs_chk fbs_chk_inst (.CLOCK, .RST, .MEM_BASE, .AVS_ADDRESS, .AVS_READ,
   .AVS_WRITE, .AVS_WRITEDATA, .AVS_IOSPACE, .AVS_READDATA, .AVS_WAITREQUEST,
   .HOST_FIFO_EMPTY, .PIPE_IDLE, .DISPLAY_BUF, .PIX_WR, .PIX_RD, .PIX_RVALID);
`default_nettype wire

// file: verif/fbs_pixmem.sv
// fbs_pixmem: pixel memory model answering the block's read strobe.
// assumes one read outstanding at a time; DLY of at least 1.
`timescale 1ns/100ps
`default_nettype none
module fbs_pixmem (
   input wire logic CLOCK, // core clock
   input wire logic PIX_RD, // read strobe
   input wire logic [9:0] PIX_X, // column
   input wire logic [9:0] PIX_Y, // row
   input wire logic [3:0] DLY, // answer delay in cycles
   output logic [15:0] PIX_RDATA, // pixel
   output logic PIX_RVALID // data valid
);
   logic [15:0] val;
   initial begin
      PIX_RDATA = 16'h0000;
      PIX_RVALID = 1'b0;
   end
   always @(posedge CLOCK) begin
      if (PIX_RD) begin
         val = {PIX_X[5:0], PIX_Y} ^ 16'h5A5A;
         repeat (DLY - 4'h1) @(posedge CLOCK);
         PIX_RDATA <= val;
         PIX_RVALID <= 1'b1;
         @(posedge CLOCK);
         PIX_RVALID <= 1'b0;
         // released data is inverted so a late sample cannot match
         PIX_RDATA <= ~val;
      end
   end
endmodule
`default_nettype wire

// file: verif/testbench.sv
// testbench: avalon host driving fbs_top, with a pixel memory model.
// assumes the design files and fbs_pixmem are compiled first.
`include "fbs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam logic [31:0] LFB = 32'h0080_0000;
   logic clk = 0, rst = 1, rd = 0, wr = 0, io = 0, vr = 0, hfe = 1, pidle = 1, vr_on = 0;
   logic [31:0] base = 32'h1000_0000, addr = 0, wdata = 0, rdata;
   logic [3:0] be = 4'hF, dly = 4'h1;
   logic [1:0] dbuf;
   logic pwr, prd, cwe, dwe, rv, wreq;
   logic [9:0] px_x, px_y;
   logic [23:0] col;
   logic [7:0] alp;
   logic [15:0] dep, pdat;
   int err_total = 0, cmp_count = 0, seed = 6842, nvr = 0;
   fbs_top fbs_top_inst (.CLOCK(clk), .RST(rst), .MEM_BASE(base), .AVS_ADDRESS(addr),
      .AVS_BYTEENABLE(be), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
      .AVS_IOSPACE(io), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .VRETRACE(vr),
      .HOST_FIFO_EMPTY(hfe), .PIPE_IDLE(pidle), .DISPLAY_BUF(dbuf), .PIX_WR(pwr),
      .PIX_RD(prd), .PIX_X(px_x), .PIX_Y(px_y), .PIX_COLOR(col), .PIX_ALPHA(alp),
      .PIX_DEPTH(dep), .PIX_CWE(cwe), .PIX_DWE(dwe), .PIX_RDATA(pdat), .PIX_RVALID(rv));
   fbs_pixmem fbs_pixmem_inst (.CLOCK(clk), .PIX_RD(prd), .PIX_X(px_x), .PIX_Y(px_y),
      .DLY(dly), .PIX_RDATA(pdat), .PIX_RVALID(rv));
   always #50 clk = ~clk;
   always begin
      @(posedge clk);
      if (vr_on) begin
         repeat (30) @(posedge clk);
         vr <= 1;
         nvr++;
         repeat (4) @(posedge clk);
         vr <= 0;
      end
   end
   function automatic logic [15:0] pix(input int x, input int y);
      return {x[5:0], y[9:0]} ^ 16'h5A5A;
   endfunction
   task automatic tally_and_finish;
      $display("mismatches %0d comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 2000);
      q = rdata;
      wr <= 0;
      rd <= 0;
      if (n >= 2000) chk("bus answer", 0, 1);
   endtask
   task automatic reg_wr(input logic [11:0] o, input logic [31:0] d);
      logic [31:0] q;
      bus(1, base + {20'h0_0000, o}, d, q);
   endtask
   task automatic wait_wr(output logic got);
      got = 0;
      repeat (4) begin
         @(posedge clk);
         if (pwr === 1'b1) begin
            got = 1;
            break;
         end
      end
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      tally_and_finish;
   end
   initial begin
      logic [31:0] q, d, cda, pm, pc;
      logic got;
      int x, y, f;
      logic [1:0] b0;
      realtime t0;
      repeat (16) @(posedge clk);
      rst <= 0;
      bus(0, base, 0, q);
      chk("pending", q[30:28], 0);
      io <= 1;
      bus(0, base, 0, q);
      chk("io read", q, 0);
      bus(1, base + LFB, 32'hFFFF_FFFF, q);
      wait_wr(got);
      chk("io write", got, 0);
      io <= 0;
      reg_wr(`FBS_REG_DIMS, 32'h01E0_0280);
      for (int i = 0; i < 24; i++) begin
         f = 4 + i % 2;
         pm = f | ($random(seed) & 32'h0000_0200);
         cda = $random(seed);
         d = $random(seed);
         pc = $random(seed) & 32'h0001_0001;
         x = {$random(seed)} % 768;
         y = {$random(seed)} % 480;
         // out-of-range writes only with clipping on, the host's duty
         if (x >= 640) pc[0] = 1;
         reg_wr(`FBS_REG_PORTMODE, pm);
         reg_wr(`FBS_REG_CDA, cda);
         reg_wr(`FBS_REG_PIXCFG, pc);
         bus(1, base + LFB + (y << 12) + (x << 2), d, q);
         wait_wr(got);
         chk("write seen", got, x < 640);
         if (x < 640) begin
            chk("x", px_x, x);
            chk("y", px_y, pc[16] ? 479 - y : y);
            chk("color", col, pm[9] ? {d[7:0], d[15:8], d[23:16]} : d[23:0]);
            chk("alpha", alp, f == 5 ? d[31:24] : cda[31:24]);
            chk("depth", dep, cda[15:0]);
         end
      end
      reg_wr(`FBS_REG_PIXCFG, 0);
      for (int i = 0; i < 4; i++) begin
         f = (i / 2) * 3;
         reg_wr(`FBS_REG_PORTMODE, f | ((i % 2) << 11));
         bus(1, base + LFB + (7 << 11) + (100 << 1), 32'hFFFF_0000, q);
         for (int k = 0; k < 2; k++) begin
            wait_wr(got);
            chk("half seen", got, 1);
            chk("half x", px_x, 100 + ((i % 2) ^ (col != 0)));
            chk("half alpha", alp, f == 3 ? {8{col != 0}} : cda[31:24]);
            chk("half depth", dep, cda[15:0]);
         end
      end
      reg_wr(`FBS_REG_PORTMODE, 12);
      bus(1, base + LFB + (3 << 12) + (9 << 2), 32'hABCD_0000, q);
      wait_wr(got);
      chk("depth pair", {got, cwe, dwe, px_x, dep}, {3'h7, 10'h009, 16'hABCD});
      for (int r = 6; r < 12; r++) begin
         reg_wr(`FBS_REG_PORTMODE, r);
         bus(1, base + LFB, 32'h1234_5678, q);
         wait_wr(got);
         chk("reserved", got, 0);
      end
      for (int b = 0; b < 2; b++) begin
         reg_wr(`FBS_REG_PORTMODE, b << 11);
         dly <= b ? 4'h4 : 4'h1;
         if (b) pidle <= 0;
         else hfe <= 0;
         t0 = $realtime;
         fork
            bus(0, base + LFB + (9 << 11) + (20 << 1), 0, q);
            begin
               repeat (12) @(posedge clk);
               hfe <= 1;
               pidle <= 1;
            end
         join
         chk("read held", $realtime - t0 > 1200.0, 1);
         chk("lfb read", q, {pix(20 + !b, 9), pix(20 + b, 9)});
      end
      b0 = dbuf;
      reg_wr(`FBS_REG_FLIPCMD, 0);
      repeat (3) @(posedge clk);
      chk("flip now", dbuf, b0 ^ 2'h1);
      bus(0, base, 0, q);
      chk("pend flat", {q[30:28], q[3:2]}, 5'h03);
      vr_on <= 1;
      for (int n = 0; n < 3; n += 2) begin
         @(negedge vr);
         repeat (3) @(posedge clk);
         b0 = dbuf;
         x = nvr;
         reg_wr(`FBS_REG_FLIPCMD, (n << 1) | 1);
         wait (dbuf != b0);
         chk("retraces", nvr - x, n + 1);
         chk("synced flip", dbuf, b0 ^ 2'h1);
      end
      vr_on <= 0;
      repeat (40) @(posedge clk);
      reg_wr(`FBS_REG_BUFMODE, 1);
      reg_wr(`FBS_REG_FLIPCMD, 1);
      bus(0, base, 0, q);
      chk("pend one", q[30:28], 1);
      x = nvr;
      vr_on <= 1;
      reg_wr(`FBS_REG_FLIPCMD, 1);
      reg_wr(`FBS_REG_FLIPCMD, 1);
      chk("stalled", nvr > x, 1);
      x = nvr;
      wait (nvr == x + 2);
      repeat (8) @(posedge clk);
      bus(0, base, 0, q);
      chk("pend drained", q[30:28], 0);
      tally_and_finish;
   end
endmodule
`default_nettype wire
